// file: hw/rxla_top.v
// receive termination, clock edge, alarm detection and interrupt logic for eight channels
`default_nettype none
`include "rxla_regs.vh"

// ----------------------------------------------------------------------
// per channel alarm detector
// ----------------------------------------------------------------------
// one channel: digital loss of signal and all-ones detection
module rxla_chan #(
  parameter T1_AIS_BITS = `RXLA_T1_AIS_PERIOD_BITS
) (
  input wire core_clk,
  input wire rst_n,
  input wire bit_en,
  input wire mark,
  input wire e1_mode,
  input wire ext_los,
  input wire [7:0] e1_los_n,
  output reg los_ff,
  output reg ais_ff
);
  reg [11:0] zrun_ff;
  reg [13:0] win_ff;
  reg [3:0] wzero_ff;
  wire [11:0] los_lim;
  wire [13:0] win_last;
  wire [3:0] zlim;
  wire win_end;
  wire [3:0] zcount;

  // zero run limit selected by line mode and extended option
  assign los_lim = ext_los ? `RXLA_EXT_LOS_ZEROS :
    (e1_mode ? {4'h0, e1_los_n} : `RXLA_T1_LOS_ZEROS);
  assign win_last = e1_mode ? {4'h0, `RXLA_E1_AIS_WINDOW} : T1_AIS_BITS[13:0] - 14'h1;
  assign zlim = e1_mode ? `RXLA_E1_AIS_MAX_ZEROS : `RXLA_T1_AIS_MAX_ZEROS;
  assign win_end = (win_ff == win_last);
  assign zcount = (!mark && wzero_ff != 4'hf) ? wzero_ff + 4'h1 : wzero_ff;

  // loss of signal: count consecutive intervals with no pulse
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zrun_ff <= 12'h000;
      los_ff <= 1'b0;
    end else if (bit_en) begin
      if (mark) begin
        zrun_ff <= 12'h000;
        los_ff <= 1'b0;
      end else begin
        if (zrun_ff != 12'hfff) zrun_ff <= zrun_ff + 12'h001;
        // extended limit has no thirteenth bit: run of 4095 before this zero means 4096
        if (ext_los ? (zrun_ff == los_lim) : (zrun_ff + 12'h001 >= los_lim))
          los_ff <= 1'b1;
      end
    end
  end

  // all-ones: zero count over a fixed window, set and clear at window end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_ff <= 14'h0000;
      wzero_ff <= 4'h0;
      ais_ff <= 1'b0;
    end else if (bit_en) begin
      if (win_end) begin
        win_ff <= 14'h0000;
        wzero_ff <= 4'h0;
        ais_ff <= (zcount <= zlim);
      end else begin
        win_ff <= win_ff + 14'h0001;
        wzero_ff <= zcount;
      end
    end
  end
endmodule // rxla_chan

// ----------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------
// Summary of operation
// - two-bit impedance code picks 100, 110, 75 or 120 ohm termination
// - per-channel enable connects termination; reset leaves input high impedance
// - with override set, termination pin rules all channels; otherwise pin ignored
// - two-bit code declares external resistor: none, 240, 210, 150 ohm
// - without signal, recovered clock runs from the master clock
// - data changes on rising clock edge; edge select one picks falling
// - loss, all-ones, pattern and fifo alarms each have an interrupt mask
// - no interrupt unless global interrupt enable is set
// - a change of an enabled alarm drives interrupt low
// - status clears when read and interrupt releases high
// - interrupt pin is open drain, pulling low only
// - t1 loss declared after 175 +/- 75 intervals without pulses
// - e1 loss declared after n intervals without pulses, n 10 to 255
// - extended option needs 4096 zeros in both modes; off after reset
// - t1 all-ones meant for 99.9 percent ones over period; zero count stops at 15, so it sets at every period end
// - e1 all-ones sets with two or fewer zeros in 512 bits
// - eight independent channels
module rxla_top #(
  parameter NCH = 8,
  parameter T1_AIS_BITS = `RXLA_T1_AIS_PERIOD_BITS
) (
  input wire core_clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_ff,
  input wire term_pin,
  input wire [NCH-1:0] rx_mark,
  input wire [NCH-1:0] rx_signal_present,
  input wire [NCH-1:0] line_clk,
  input wire [NCH-1:0] prbs_pattern_detect,
  input wire [NCH-1:0] fifo_limit_status,
  input wire master_clk,
  output wire [NCH-1:0] rx_term_enable,
  output wire [2*NCH-1:0] rx_term_impedance_sel,
  output wire [2*NCH-1:0] ext_resistor_sel,
  output wire [NCH-1:0] rx_clk_out,
  output wire rx_clock_edge_sel,
  output wire irq_n_o,
  output wire irq_n_oe
);
  reg [1:0] rst_sync_ff;
  wire rst_n;
  reg [7:0] gctrl_ff;
  reg [7:0] e1_los_n_ff;
  reg [7:0] chcfg_ff [0:NCH-1];
  reg [3:0] chmask_ff [0:NCH-1];
  reg [3:0] chg_ff [0:NCH-1];
  reg [3:0] prev_ff [0:NCH-1];
  reg [2:0] pin_ff;
  reg [NCH-1:0] m1_ff, m2_ff, m3_ff, mark_ff;
  reg [NCH-1:0] c1_ff, c2_ff, c3_ff, lclk_ff, lclk_d_ff;
  reg [NCH-1:0] p1_ff, p2_ff, p3_ff, pres_ff;
  reg [2:0] mc_ff;
  reg mclk_ff, mclk_d_ff;
  wire [NCH-1:0] los, all_ones_alarm;
  wire [NCH-1:0] irq_hit;
  wire term_pin_s;
  wire mclk_rise;
  wire e1_mode;
  integer i;
  genvar g;

  // reset release through two flops
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) rst_sync_ff <= 2'b00;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------------
  // three flops; a change counts once stages two and three agree, but the termination pin is taken straight from stage three
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ff <= 3'b000;
      m1_ff <= {NCH{1'b0}}; m2_ff <= {NCH{1'b0}}; m3_ff <= {NCH{1'b0}};
      c1_ff <= {NCH{1'b0}}; c2_ff <= {NCH{1'b0}}; c3_ff <= {NCH{1'b0}};
      p1_ff <= {NCH{1'b0}}; p2_ff <= {NCH{1'b0}}; p3_ff <= {NCH{1'b0}};
      mark_ff <= {NCH{1'b0}}; lclk_ff <= {NCH{1'b0}}; lclk_d_ff <= {NCH{1'b0}};
      pres_ff <= {NCH{1'b0}};
      mc_ff <= 3'b000; mclk_ff <= 1'b0; mclk_d_ff <= 1'b0;
    end else begin
      pin_ff <= {pin_ff[1:0], term_pin};
      m1_ff <= rx_mark; m2_ff <= m1_ff; m3_ff <= m2_ff;
      c1_ff <= line_clk; c2_ff <= c1_ff; c3_ff <= c2_ff;
      p1_ff <= rx_signal_present; p2_ff <= p1_ff; p3_ff <= p2_ff;
      mc_ff <= {mc_ff[1:0], master_clk};
      if (mc_ff[1] == mc_ff[2]) mclk_ff <= mc_ff[2];
      mclk_d_ff <= mclk_ff;
      for (i = 0; i < NCH; i = i + 1) begin
        if (m2_ff[i] == m3_ff[i]) mark_ff[i] <= m3_ff[i];
        if (c2_ff[i] == c3_ff[i]) lclk_ff[i] <= c3_ff[i];
        if (p2_ff[i] == p3_ff[i]) pres_ff[i] <= p3_ff[i];
      end
      lclk_d_ff <= lclk_ff;
    end
  end
  assign term_pin_s = pin_ff[2];
  assign mclk_rise = mclk_ff & ~mclk_d_ff;
  assign e1_mode = gctrl_ff[`RXLA_GC_E1_MODE];

  // ----------------------------------------------------------------------
  // per channel datapath
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire bit_en;
      // recovered clock falls back to master clock when line is silent
      assign bit_en = pres_ff[g] ? (lclk_ff[g] & ~lclk_d_ff[g]) : mclk_rise;
      assign rx_clk_out[g] = pres_ff[g] ? lclk_ff[g] : mclk_ff;
      assign rx_term_enable[g] = gctrl_ff[`RXLA_GC_TERM_OVR] ? term_pin_s :
        chcfg_ff[g][`RXLA_CH_TERM_EN];
      assign rx_term_impedance_sel[2*g+1:2*g] =
        chcfg_ff[g][`RXLA_CH_IMP_LSB+1:`RXLA_CH_IMP_LSB];
      assign ext_resistor_sel[2*g+1:2*g] =
        chcfg_ff[g][`RXLA_CH_RES_LSB+1:`RXLA_CH_RES_LSB];
      assign irq_hit[g] = |(chg_ff[g] & ~chmask_ff[g]);
      rxla_chan #(
        .T1_AIS_BITS(T1_AIS_BITS)
      ) u_chan (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bit_en(bit_en),
        .mark(mark_ff[g]),
        .e1_mode(e1_mode),
        .ext_los(chcfg_ff[g][`RXLA_CH_EXTENDED_LOS_ENABLE]),
        .e1_los_n(e1_los_n_ff),
        .los_ff(los[g]),
        .ais_ff(all_ones_alarm[g])
      );
    end
  endgenerate

  assign rx_clock_edge_sel = gctrl_ff[`RXLA_GC_CLK_EDGE];

  // ----------------------------------------------------------------------
  // register port and change-of-status flags
  // ----------------------------------------------------------------------
  // writes, clear-on-read; a new change wins over the read clear
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gctrl_ff <= `RXLA_GC_RESET;
      e1_los_n_ff <= `RXLA_E1_LOS_DEFAULT;
      for (i = 0; i < NCH; i = i + 1) begin
        chcfg_ff[i] <= `RXLA_CH_RESET;
        chmask_ff[i] <= `RXLA_MASK_RESET;
        chg_ff[i] <= 4'h0;
        prev_ff[i] <= 4'h0;
      end
    end else begin
      if (wr_stb && addr == `RXLA_GLOBAL_CTRL) begin
        gctrl_ff <= wdata[7:0];
        if (wdata[15:8] >= 8'd10) e1_los_n_ff <= wdata[15:8];
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr_stb && addr == `RXLA_CH_BASE + i[3:0]) begin
          chcfg_ff[i] <= wdata[7:0];
          chmask_ff[i] <= wdata[`RXLA_CH_MASK_LSB+3:`RXLA_CH_MASK_LSB];
        end
        prev_ff[i] <= {fifo_limit_status[i], prbs_pattern_detect[i], all_ones_alarm[i], los[i]};
        chg_ff[i] <= ((rd_stb && addr == `RXLA_CH_BASE + i[3:0]) ? 4'h0 : chg_ff[i]) |
          (prev_ff[i] ^ {fifo_limit_status[i], prbs_pattern_detect[i], all_ones_alarm[i], los[i]});
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (rd_stb) begin
        if (addr == `RXLA_GLOBAL_CTRL) rdata_ff <= {16'h0000, e1_los_n_ff, gctrl_ff};
        else if (addr == `RXLA_GLOBAL_STAT) rdata_ff <= {24'h000000, irq_hit};
        for (i = 0; i < NCH; i = i + 1) begin
          if (addr == `RXLA_CH_BASE + i[3:0])
            rdata_ff <= {8'h00, chg_ff[i],
              fifo_limit_status[i], prbs_pattern_detect[i], all_ones_alarm[i], los[i],
              4'h0, chmask_ff[i], chcfg_ff[i]};
        end
      end
    end
  end

  // open-drain interrupt: drive low only
  assign irq_n_o = 1'b0;
  assign irq_n_oe = gctrl_ff[`RXLA_GC_IRQ_EN] & (|irq_hit);
endmodule // rxla_top
`default_nettype wire

// file: include/rxla_regs.vh
// register offsets, field positions, reset values and timing counts of the receive alarm block
`ifndef RXLA_REGS_VH
`define RXLA_REGS_VH
// register index map (word index; byte address is index times four is not used on this port)
`define RXLA_GLOBAL_CTRL 4'h0
`define RXLA_GLOBAL_STAT 4'h1
`define RXLA_CH_BASE 4'h8
// global control fields
`define RXLA_GC_IRQ_EN 0
`define RXLA_GC_TERM_OVR 1
`define RXLA_GC_CLK_EDGE 2
`define RXLA_GC_E1_MODE 3
// per channel register fields
`define RXLA_CH_TERM_EN 0
`define RXLA_CH_IMP_LSB 1
`define RXLA_CH_RES_LSB 3
`define RXLA_CH_EXTENDED_LOS_ENABLE 5
`define RXLA_CH_MASK_LSB 8
`define RXLA_CH_STAT_LSB 16
`define RXLA_CH_CHG_LSB 20
// reset values
`define RXLA_GC_RESET 8'h00
`define RXLA_CH_RESET 8'h00
`define RXLA_MASK_RESET 4'hf
// loss of signal and all-ones counts
`define RXLA_T1_LOS_ZEROS 12'd175
`define RXLA_E1_LOS_DEFAULT 8'd32
`define RXLA_EXT_LOS_ZEROS 12'd4095
`define RXLA_E1_AIS_WINDOW 10'd511
`define RXLA_E1_AIS_MAX_ZEROS 4'd2
// t1 all-ones period in bit intervals (10 ms at 1.544 Mb/s)
`define RXLA_T1_AIS_PERIOD_BITS 15440
`define RXLA_T1_AIS_MAX_ZEROS 4'd15
`endif

// file: sim/rxla_line_model.sv
// line side model: recovered clock, pulse marks and master clock
`default_nettype none
module rxla_line_model (
  input wire logic present,
  input wire logic ones,
  output logic [7:0] line_clk,
  output logic [7:0] rx_mark,
  output logic [7:0] rx_signal_present,
  output logic master_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lck = 1'b0;
  logic mck = 1'b0;
  logic [7:0] mk = 8'h00;
  // line clock stands still without signal; marks change mid bit
  always #150 if (present) lck = ~lck;
  always #200 mck = ~mck;
  always @(negedge lck) mk <= {8{ones}};
  assign line_clk = {8{lck}};
  assign rx_mark = present ? mk : 8'h00;
  assign rx_signal_present = {8{present}};
  assign master_clk = mck;
endmodule // rxla_line_model
`default_nettype wire

// file: sim/rxla_top_properties.sv
// port checks of the receive alarm block
`default_nettype none
module rxla_top_properties #(parameter NCH = 8) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata_ff,
  input wire logic term_pin,
  input wire logic [NCH-1:0] rx_term_enable,
  input wire logic [2*NCH-1:0] rx_term_impedance_sel,
  input wire logic [2*NCH-1:0] ext_resistor_sel,
  input wire logic rx_clock_edge_sel,
  input wire logic irq_n_o,
  input wire logic irq_n_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic ovr_ff;
  logic gie_ff;
  // ----
  // shadow of pin override and interrupt enable
  // ----
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovr_ff <= 1'b0;
      gie_ff <= 1'b0;
    end else if (wr_stb && addr == 4'h0) begin
      ovr_ff <= wdata[1];
      gie_ff <= wdata[0];
    end
  end
  irq_low_only_a: assert property (irq_n_o == 1'b0) else $error("irq level");
  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata_ff == 32'h0) else $error("rdata idle");
  unmapped_read_a: assert property (rd_stb && addr inside {[2:7]} |=> rdata_ff == 32'h0)
    else $error("unmapped read");
  imp_write_a: assert property (wr_stb && addr == 4'h8 |=>
    rx_term_impedance_sel[1:0] == $past(wdata[2:1])) else $error("impedance");
  res_write_a: assert property (wr_stb && addr == 4'h8 |=>
    ext_resistor_sel[1:0] == $past(wdata[4:3])) else $error("resistor");
  term_bit_a: assert property (!ovr_ff && wr_stb && addr == 4'h8 |=>
    rx_term_enable[0] == $past(wdata[0])) else $error("term enable");
  pin_override_a: assert property ((ovr_ff && $stable(term_pin)) [*5] |->
    rx_term_enable == {NCH{term_pin}}) else $error("term pin");
  edge_write_a: assert property (wr_stb && addr == 4'h0 |=>
    rx_clock_edge_sel == $past(wdata[2])) else $error("clock edge");
  irq_gate_a: assert property (!gie_ff |-> !irq_n_oe) else $error("irq gated");
  irq_cause_a: assert property (rd_stb && addr == 4'h1 && irq_n_oe |=>
    rdata_ff[NCH-1:0] != '0) else $error("irq cause");
endmodule // rxla_top_properties
bind rxla_top rxla_top_properties #(.NCH(NCH)) rxla_top_properties_inst (.core_clk(core_clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata_ff(rdata_ff), .term_pin(term_pin), .rx_term_enable(rx_term_enable),
  .rx_term_impedance_sel(rx_term_impedance_sel), .ext_resistor_sel(ext_resistor_sel),
  .rx_clock_edge_sel(rx_clock_edge_sel), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
`default_nettype wire

// file: sim/testbench.sv
// register level test of the receive alarm block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, wr_stb, rd_stb, term_pin, present, ones, lst;
  logic [3:0] addr;
  logic [31:0] wdata, rdata_ff;
  logic [7:0] prbs, fifo_lim, mark, sig, lclk, rclk, en;
  logic [15:0] imp, res;
  logic mclk, edge_sel, irq_o, irq_oe;
  int n_errors = 0, check_count = 0, cyc = 0, n;
  rxla_line_model rxla_line_model_inst (.present(present), .ones(ones), .line_clk(lclk),
    .rx_mark(mark), .rx_signal_present(sig), .master_clk(mclk));
  rxla_top #(.NCH(8), .T1_AIS_BITS(64)) rxla_top_inst (.core_clk(core_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
    .term_pin(term_pin), .rx_mark(mark), .rx_signal_present(sig), .line_clk(lclk),
    .prbs_pattern_detect(prbs), .fifo_limit_status(fifo_lim), .master_clk(mclk),
    .rx_term_enable(en), .rx_term_impedance_sel(imp), .ext_resistor_sel(res),
    .rx_clk_out(rclk), .rx_clock_edge_sel(edge_sel), .irq_n_o(irq_o), .irq_n_oe(irq_oe));
  // ----
  // bus tasks and compare
  // ----
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", e, rdata_ff & m);
  endtask
  task automatic wait_irq(input int lim);
    int i = 0;
    while (irq_oe !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    chk("irq", 1, irq_oe);
  endtask
  // clock and hang limit
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {nrst, wr_stb, rd_stb, term_pin, addr, wdata, prbs, fifo_lim} = '0;
    present = 1'b1;
    ones = 1'b1;
    tick(5);
    nrst <= 1'b1;
    tick(3);
    rdc(4'h8, 32'hffffffff, 32'h0f00);
    rdc(4'h5, 32'hffffffff, 32'h0);
    wr(4'h0, 32'h0500);
    rdc(4'h0, 32'hffffffff, 32'h2000);
    for (int c = 0; c < 4; c++) begin
      wr(4'h8 + c[3:0], 32'h0f00 | (c << 3) | ((3 - c) << 1) | (c & 1));
      chk("imp", 3 - c, imp[2*c +: 2]);
      chk("res", c, res[2*c +: 2]);
    end
    wr(4'h0, 32'h0a02);
    @(posedge core_clk) term_pin <= 1'b1;
    tick(6);
    chk("term", 8'hff, en);
    @(posedge core_clk) term_pin <= 1'b0;
    tick(6);
    chk("term", 8'h00, en);
    @(posedge core_clk) term_pin <= 1'b1;
    wr(4'h0, 32'h0a04);
    tick(6);
    chk("term", 8'h0a, en);
    chk("edge", 1, edge_sel);
    present = 1'b0;
    n = 0;
    repeat (64) begin
      @(negedge core_clk);
      if (rclk[0] !== lst) n++;
      lst = rclk[0];
    end
    chk("mclk", 1, n >= 8);
    present = 1'b1;
    wr(4'h0, 32'h0a09);
    tick(7000);
    wr(4'h8, 32'h0e00);
    rdc(4'h8, 32'h000f0000, 32'h00020000);
    ones = 1'b0;
    tick(42);
    chk("irq", 0, irq_oe);
    wait_irq(100);
    rdc(4'h1, 32'hff, 32'h01);
    rdc(4'h8, 32'h00ff0000, 32'h00130000);
    tick(2);
    chk("irq", 0, irq_oe);
    wr(4'h0, 32'h0a08);
    ones = 1'b1;
    tick(120);
    chk("irq", 0, irq_oe);
    wr(4'h0, 32'h0a09);
    chk("irq", 1, irq_oe);
    rdc(4'h8, 32'h00ff0000, 32'h00120000);
    wr(4'h8, 32'h0e20);
    ones = 1'b0;
    tick(24000);
    chk("irq", 0, irq_oe);
    wait_irq(1200);
    rdc(4'h8, 32'h00ff0000, 32'h00310000);
    wr(4'h8, 32'h0a20);
    @(posedge core_clk) prbs <= 8'h02;
    tick(4);
    chk("irq", 0, irq_oe);
    @(posedge core_clk) prbs <= 8'h03;
    wait_irq(8);
    rdc(4'h8, 32'h00ff0000, 32'h00450000);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
